/* design/adc_cal_ready.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - The master clock pin is halved to form the modulator clock.
// - A sample set is produced every oversampling-ratio modulator ticks.
// - A new sample set drives the sample-ready pin low to tell the host.
// - Each channel subtracts its high/low offset value from every result.
// - Each corrected result is scaled by the channel's high/low gain factor.
// - Each channel samples at its own phase delay from its config register.
// - The clock register holds the ratio, channel enables and power mode.
// - Channel amplifier gains come from two gain registers, gain 1 valid.
// - A selectable DC-blocking filter can replace the offset values.
// - Each channel's input source is chosen in its config register.
// - Results sit in a two-entry queue; unread, the pin pulses every other.
module adc_cal_ready
  import adc_cal_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire logic      masterClockIn,
  input  wire frame_t    convIn,
  input  wire apbReq_s   apbIn,
  output apbRsp_s        apbOut,
  output logic           sampleReadyN,
  output logic           irq
);

  typedef struct packed {
    logic [2:0]        mclkSync;
    logic              modPhase;
    logic [14:0]       modCount;
    logic [31:0]       clockCfg;
    logic [23:0]       gainA;
    logic [7:0]        gainB;
    logic              dcBlockEn;
    logic [1:0]        status;
    logic [1:0]        mask;
    chanCal_s [NUM_CH-1:0] cal;
    frame_t            held;
    frame_t            dcEst;
    frame_t [1:0]      fifo;
    logic [1:0]        level;
    logic [NUM_CH-1:0] readMask;
    logic              ovfPhase;
    logic              readyN;
    logic [7:0]        pulseCnt;
  } state_s;

  // current and next copy of the whole state
  state_s st_reg;
  state_s st_next;

  // correction of one channel: offset, amplifier gain, gain factor
  // the difference is widened by one bit so it cannot wrap
  function automatic word_t correct(word_t x, logic [2:0] g,
                                    word_t off, word_t gc);
    logic signed [24:0] diff;
    logic signed [32:0] amp;
    logic signed [57:0] prod;
    logic signed [57:0] sh;
    diff = $signed({x[23], x}) - $signed({off[23], off});
    amp  = $signed({{8{diff[24]}}, diff}) <<< g;
    prod = amp * $signed({1'b0, gc});
    sh   = prod >>> GCAL_FRAC;
    // saturate rather than wrap, so a large gain never flips the sign
    if (sh > 58'sh7f_ffff) begin
      correct = 24'h7f_ffff;
    end else if (sh < -58'sh80_0000) begin
      correct = 24'h80_0000;
    end else begin
      correct = sh[23:0];
    end
  endfunction

  // last modulator count of a period for a ratio code
  // the ratio doubles with each step of the code
  function automatic logic [14:0] osrLast(logic [2:0] code);
    osrLast = (OSR_BASE << code) - 15'h0001;
  endfunction

  // source selection for one channel
  // test codes give fixed levels for checking the path
  function automatic word_t muxIn(logic [1:0] sel, word_t ext);
    case (sel)
      MUX_EXT:   muxIn = ext;
      MUX_SHORT: muxIn = 24'h00_0000;
      MUX_POS:   muxIn = TEST_POS;
      default:   muxIn = TEST_NEG;
    endcase
  endfunction

  // combinational helpers
  logic              mclkRise;
  logic              modTick;
  logic              sampleTick;
  logic              access;
  logic              hit;
  logic [11:0]       addr;
  logic [31:0]       rdData;
  logic [2:0]        osrCode;
  logic [23:0]       gainAll;
  logic              pushPulse;
  logic              overflow;
  logic              popFrame;
  logic [NUM_CH-1:0] maskNow;
  logic [11:0]       chOfs;
  logic [2:0]        chIdx;
  logic [4:0]        sub;
  logic [2:0]        dIdx;
  word_t             capVal;
  word_t             offUse;
  logic [24:0]       dcDiff;
  frame_t            result;
  logic [1:0]        events;

  // address decode helpers; channel registers sit in 32-byte slots
  assign addr    = apbIn.paddr;
  assign access  = apbIn.psel & apbIn.penable;
  assign osrCode = st_reg.clockCfg[CLK_OSR_LSB +: 3];
  assign gainAll = {st_reg.gainB, st_reg.gainA[15:0]};
  assign chOfs   = addr - CHAN_BASE;
  assign chIdx   = chOfs[7:5];
  assign sub     = chOfs[4:0];
  assign dIdx    = 3'(addr[4:2]);

  // modulator tick on every second rising master-clock edge
  // the pin is synchronised first, mclkSync[2] only delays for the edge
  assign mclkRise   = st_reg.mclkSync[1] & ~st_reg.mclkSync[2];
  assign modTick    = mclkRise & st_reg.modPhase;
  // compare with >= so a ratio cut in mid-period ends the period at once
  // instead of letting the count run round all fifteen bits
  assign sampleTick = modTick &&
                      (st_reg.modCount >= osrLast(osrCode));

  // register read mux and address check
  // a read never changes state except status and the queue
  always_comb begin
    rdData = 32'h0000_0000;
    hit    = 1'b0;
    if (addr[1:0] == 2'h0) begin
      if (addr >= CHAN_BASE && addr < CHAN_END) begin
        if (chIdx < 3'(NUM_CH)) begin
          hit = 1'b1;
          case (sub)
            CFG_SUB: rdData = 32'({st_reg.cal[chIdx].mux, 2'h0,
                                   st_reg.cal[chIdx].phase});
            OCALH_SUB: rdData = 32'(st_reg.cal[chIdx].offset[23:8]);
            OCALL_SUB: rdData = 32'(st_reg.cal[chIdx].offset[7:0]);
            GCALH_SUB: rdData = 32'(st_reg.cal[chIdx].gcal[23:8]);
            GCALL_SUB: rdData = 32'(st_reg.cal[chIdx].gcal[7:0]);
            default:   hit = 1'b0;
          endcase
        end
      end else if (addr >= DATA_BASE && addr < DATA_END) begin
        hit = 1'b1;
        if (st_reg.level != 2'h0) begin
          rdData = 32'(st_reg.fifo[0][dIdx]);
        end
      end else begin
        hit = 1'b1;
        case (addr)
          CLOCK_OFS:  rdData = st_reg.clockCfg;
          GAIN_A_OFS: rdData = 32'(st_reg.gainA);
          GAIN_B_OFS: rdData = 32'(st_reg.gainB);
          MODE_OFS:   rdData = 32'(st_reg.dcBlockEn);
          STATUS_OFS: rdData = 32'(st_reg.status);
          MASK_OFS:   rdData = 32'(st_reg.mask);
          LEVEL_OFS:  rdData = 32'(st_reg.level);
          default:    hit = 1'b0;
        endcase
      end
    end
  end

  // zero-wait slave: the access phase always completes
  // pslverr only in the access phase, so idle cycles never flag
  assign apbOut.prdata  = rdData;
  assign apbOut.pready  = 1'b1;
  assign apbOut.pslverr = access & ~hit;

  // per-channel capture and correction, all lanes independent
  // a disabled channel reads back as zero
  always_comb begin
    result = '0;
    capVal = '0;
    offUse = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      capVal = st_reg.held[i];
      if (modTick && st_reg.modCount == 15'(st_reg.cal[i].phase)) begin
        capVal = muxIn(st_reg.cal[i].mux, convIn[i]);
      end
      // the dc estimate stands in for the programmed offset
      offUse = st_reg.dcBlockEn ? st_reg.dcEst[i]
                                : st_reg.cal[i].offset;
      if (st_reg.clockCfg[CLK_EN_LSB + i]) begin
        result[i] = correct(capVal, gainAll[4*i +: 3], offUse,
                            st_reg.cal[i].gcal);
      end
    end
  end

  // queue control
  // a frame is popped only once every data word was read; overflow drops one unread
  assign maskNow  = st_reg.readMask |
                    ((access && !apbIn.pwrite && addr >= DATA_BASE &&
                      addr < DATA_END && addr[1:0] == 2'h0)
                     ? NUM_CH'(1) << dIdx : '0);
  assign popFrame = (st_reg.level != 2'h0) && (&maskNow);
  assign overflow = sampleTick && (st_reg.level == 2'h2) && !popFrame;
  // while overflowing, only every other period is announced
  assign pushPulse = sampleTick && !(overflow && st_reg.ovfPhase);
  // event bits in status order: overflow, new frame
  assign events = {overflow, sampleTick};

  // next state
  // one big next-state process keeps the whole state in one struct
  always_comb begin
    st_next = st_reg;
    st_next.mclkSync = {st_reg.mclkSync[1:0], masterClockIn};
    if (mclkRise) begin
      st_next.modPhase = ~st_reg.modPhase;
    end
    if (modTick) begin
      st_next.modCount = sampleTick ? 15'h0000
                                    : st_reg.modCount + 15'h0001;
    end
    // hold each channel's value taken at its own phase point
    // a phase at or beyond the ratio never refreshes that channel
    for (int i = 0; i < NUM_CH; i++) begin
      dcDiff = 25'h0;
      if (modTick && st_reg.modCount == 15'(st_reg.cal[i].phase)) begin
        st_next.held[i] = muxIn(st_reg.cal[i].mux, convIn[i]);
      end
      if (sampleTick) begin
        dcDiff = $signed({st_next.held[i][23], st_next.held[i]}) -
                 $signed({st_reg.dcEst[i][23], st_reg.dcEst[i]});
        st_next.dcEst[i] = st_reg.dcEst[i] +
                           24'($signed(dcDiff) >>> DC_SHIFT);
      end
    end
    // register writes on the access phase
    // unmapped or misaligned writes never reach here, hit is low
    if (access && apbIn.pwrite && hit) begin
      if (addr >= CHAN_BASE && addr < CHAN_END) begin
        case (sub)
          CFG_SUB: begin
            st_next.cal[chIdx].phase = apbIn.pwdata[CFG_PH_LSB +: 10];
            st_next.cal[chIdx].mux   = apbIn.pwdata[CFG_MUX_LSB +: 2];
          end
          OCALH_SUB: st_next.cal[chIdx].offset[23:8] = apbIn.pwdata[15:0];
          OCALL_SUB: st_next.cal[chIdx].offset[7:0]  = apbIn.pwdata[7:0];
          GCALH_SUB: st_next.cal[chIdx].gcal[23:8]   = apbIn.pwdata[15:0];
          GCALL_SUB: st_next.cal[chIdx].gcal[7:0]    = apbIn.pwdata[7:0];
          default: ;
        endcase
      end else begin
        case (addr)
          CLOCK_OFS: st_next.clockCfg = {15'h0000,
                                         apbIn.pwdata[CLK_HR_BIT],
                                         5'h00,
                                         apbIn.pwdata[CLK_OSR_LSB +: 3],
                                         2'h0,
                                         apbIn.pwdata[5:0]};
          GAIN_A_OFS: st_next.gainA = apbIn.pwdata[23:0] & 24'h77_7777;
          GAIN_B_OFS: st_next.gainB = apbIn.pwdata[7:0] & 8'h77;
          MODE_OFS:   st_next.dcBlockEn = apbIn.pwdata[MODE_DCB_BIT];
          MASK_OFS:   st_next.mask = apbIn.pwdata[1:0];
          default: ;
        endcase
      end
    end
    // sticky status: a read clears, a same-cycle event still sets
    // irq follows on the next cycle
    if (access && !apbIn.pwrite && addr == STATUS_OFS) begin
      st_next.status = events;
    end else begin
      st_next.status = st_reg.status | events;
    end
    // two-entry queue; overflow drops the oldest frame
    // popping and pushing in one cycle keeps the level unchanged
    st_next.readMask = maskNow;
    if (popFrame) begin
      st_next.readMask = '0;
    end else if (st_reg.level == 2'h0) begin
      st_next.readMask = '0;
    end
    if (sampleTick && popFrame) begin
      if (st_reg.level == 2'h2) begin
        st_next.fifo[0] = st_reg.fifo[1];
        st_next.fifo[1] = result;
      end else begin
        st_next.fifo[0] = result;
      end
    end else if (sampleTick) begin
      if (st_reg.level == 2'h2) begin
        st_next.fifo[0] = st_reg.fifo[1];
        st_next.fifo[1] = result;
      end else begin
        st_next.fifo[st_reg.level[0]] = result;
        st_next.level = st_reg.level + 2'h1;
      end
    end else if (popFrame) begin
      st_next.fifo[0] = st_reg.fifo[1];
      st_next.level = st_reg.level - 2'h1;
    end
    // track alternate overflow periods for the pin
    if (overflow) begin
      st_next.ovfPhase = ~st_reg.ovfPhase;
    end else if (sampleTick) begin
      st_next.ovfPhase = 1'b1;
    end
    // sample-ready pin: a timed low pulse per announced frame
    // the pulse is timed in clk cycles, not modulator ticks
    if (pushPulse) begin
      st_next.readyN   = 1'b0;
      st_next.pulseCnt = 8'(READY_PULSE_CYC - 1);
    end else if (st_reg.pulseCnt != 8'h00) begin
      st_next.pulseCnt = st_reg.pulseCnt - 8'h01;
    end else begin
      st_next.readyN = 1'b1;
    end
  end

  // state register with synchronous reset
  // calibration gain resets to unity so an unset channel passes through
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg           <= '0;
      st_reg.clockCfg  <= CLOCK_RST;
      st_reg.readyN    <= 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        st_reg.cal[i].gcal <= GCAL_UNITY;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // pin straight from a flip-flop; irq is gated from the status and mask flip-flops
  assign sampleReadyN = st_reg.readyN;
  assign irq = |(st_reg.status & st_reg.mask);

endmodule // adc_cal_ready

/* design/adc_cal_pkg.sv */
package adc_cal_pkg;
  localparam int NUM_CH = 6;
  localparam int DATA_W = 24;

  // register byte offsets
  localparam logic [11:0] CLOCK_OFS   = 12'h000;
  localparam logic [11:0] GAIN_A_OFS  = 12'h004;
  localparam logic [11:0] GAIN_B_OFS  = 12'h008;
  localparam logic [11:0] MODE_OFS    = 12'h00c;
  localparam logic [11:0] STATUS_OFS  = 12'h010;
  localparam logic [11:0] MASK_OFS    = 12'h014;
  localparam logic [11:0] LEVEL_OFS   = 12'h018;
  localparam logic [11:0] CHAN_BASE   = 12'h040;
  localparam logic [11:0] CHAN_END    = 12'h100;
  localparam logic [4:0]  CFG_SUB     = 5'h00;
  localparam logic [4:0]  OCALH_SUB   = 5'h04;
  localparam logic [4:0]  OCALL_SUB   = 5'h08;
  localparam logic [4:0]  GCALH_SUB   = 5'h0c;
  localparam logic [4:0]  GCALL_SUB   = 5'h10;
  localparam logic [11:0] DATA_BASE   = 12'h100;
  localparam logic [11:0] DATA_END    = 12'h118;

  // field positions
  localparam int CLK_EN_LSB   = 0;
  localparam int CLK_OSR_LSB  = 8;
  localparam int CLK_HR_BIT   = 16;
  localparam int CFG_PH_LSB   = 0;
  localparam int CFG_MUX_LSB  = 12;
  localparam int MODE_DCB_BIT = 0;
  localparam int STAT_NEW_BIT = 0;
  localparam int STAT_OVF_BIT = 1;

  // reset values: ratio 512, all channels on, high resolution
  localparam logic [31:0] CLOCK_RST = 32'h0001_023f;
  localparam logic [23:0] GCAL_UNITY = 24'h80_0000;
  localparam logic [14:0] OSR_BASE = 15'h0080;
  localparam int GCAL_FRAC = 23;
  localparam int DC_SHIFT  = 6;

  // timing of the low pulse on the sample-ready pin
  localparam int CLK_PERIOD_NS   = 8;
  localparam int READY_PULSE_NS  = 500;
  localparam int READY_PULSE_CYC =
    (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // input selection codes
  localparam logic [1:0] MUX_EXT  = 2'h0;
  localparam logic [1:0] MUX_SHORT = 2'h1;
  localparam logic [1:0] MUX_POS  = 2'h2;
  localparam logic [23:0] TEST_POS = 24'h40_0000;
  localparam logic [23:0] TEST_NEG = 24'hc0_0000;

  typedef logic [DATA_W-1:0] word_t;
  typedef word_t [NUM_CH-1:0] frame_t;

  typedef struct packed {
    logic [9:0]  phase;
    logic [1:0]  mux;
    logic [23:0] offset;
    logic [23:0] gcal;
  } chanCal_s;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apbReq_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apbRsp_s;
endpackage

/* verif/adc_cal_ready_properties.sv */
`timescale 1ns/10ps
// watches the top ports of the converter block only
module adc_cal_ready_properties
  import adc_cal_pkg::*;
(
  input wire logic    clk,
  input wire logic    resetn,
  input wire logic    masterClockIn,
  input wire frame_t  convIn,
  input wire apbReq_s apbIn,
  input wire apbRsp_s apbOut,
  input wire logic    sampleReadyN,
  input wire logic    irq
);
  logic [7:0] lowCnt;
  logic       maskNew;
  logic       acc;

  // an access phase is under way
  assign acc = apbIn.psel && apbIn.penable;

  // pulse length so far, and the mask bit as software last wrote it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lowCnt  <= 8'h00;
      maskNew <= 1'b0;
    end else begin
      lowCnt <= sampleReadyN ? 8'h00 : lowCnt + 8'h01;
      if (acc && apbIn.pwrite && apbIn.paddr == MASK_OFS)
        maskNew <= apbIn.pwdata[STAT_NEW_BIT];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_PULSE_LEN: assert property (
    $rose(sampleReadyN) |-> lowCnt == READY_PULSE_CYC[7:0])
    else $error("ready pulse length wrong");
  AST_PULSE_HOLD: assert property (
    $fell(sampleReadyN) |=> !sampleReadyN [*8])
    else $error("ready pulse ended early");
  AST_IRQ_ON_FRAME: assert property (
    $fell(sampleReadyN) && maskNew |-> irq)
    else $error("unmasked frame did not raise irq");
  AST_MASK_OFF: assert property (
    acc && apbIn.pwrite && apbIn.paddr == MASK_OFS && apbIn.pwdata == 32'h0
    |=> !irq) else $error("irq high with all masked");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !resetn |=> sampleReadyN && !irq) else $error("outputs busy after reset");
  AST_PREADY: assert property (acc |-> apbOut.pready)
    else $error("no ready in access phase");
  AST_ALIGN_ERR: assert property (
    acc && apbIn.paddr[1:0] != 2'h0 |-> apbOut.pslverr)
    else $error("misaligned access not refused");
  AST_ERR_ZERO: assert property (
    acc && !apbIn.pwrite && apbOut.pslverr |-> apbOut.prdata == 32'h0)
    else $error("refused read returned data");
  AST_NO_ERR_IDLE: assert property (!acc |-> !apbOut.pslverr)
    else $error("error flag outside access");

  cover property ($fell(sampleReadyN));
  cover property ($rose(irq));
  cover property (acc && apbOut.pslverr);
endmodule // adc_cal_ready_properties

bind adc_cal_ready adc_cal_ready_properties u_props (
  .clk(clk), .resetn(resetn), .masterClockIn(masterClockIn),
  .convIn(convIn), .apbIn(apbIn), .apbOut(apbOut),
  .sampleReadyN(sampleReadyN), .irq(irq));

/* verif/host_mcu_model.sv */
`timescale 1ns/10ps
// host side: runs the master clock freely and counts announcements
module host_mcu_model #(
  parameter int HALF_NS = 16
) (
  input  wire logic sampleReadyN,
  output logic      masterClockIn,
  output int        readyCount
);
  // offset start so no master-clock edge falls on a clk edge
  initial begin
    masterClockIn = 1'b0;
    readyCount = 0;
    #3;
    forever #(HALF_NS) masterClockIn = ~masterClockIn;
  end

  // only the falling edge is the cue to fetch a frame
  always @(negedge sampleReadyN) readyCount++;
endmodule // host_mcu_model

/* verif/tb.sv */
`timescale 1ns/10ps
module tb
  import adc_cal_pkg::*;
;
  localparam int PERIOD = 2 * 128 * 4; // osr code 0, master clock 4 clk
  localparam logic [23:0] CAL_EXP [6] = '{24'h00_0780, 24'h00_0100,
    24'h40_0000, 24'hc0_0000, 24'h00_0200, 24'h00_0000};
  logic        clk;
  logic        resetn;
  frame_t      convIn;
  apbReq_s     req;
  apbRsp_s     rsp;
  logic        mclk;
  logic        readyN;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          readyCount;
  int          n_errors;
  int          n_checks;
  int          cyc;

  adc_cal_ready u_adc_cal_ready (.clk(clk), .resetn(resetn),
    .masterClockIn(mclk), .convIn(convIn), .apbIn(req), .apbOut(rsp),
    .sampleReadyN(readyN), .irq(irq));
  host_mcu_model u_host_mcu_model (.sampleReadyN(readyN),
    .masterClockIn(mclk), .readyCount(readyCount));

  // 125 MHz clock and a free cycle count for spacing measurements
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; result left in rd and err
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      wrap_up;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic [11:0] chan(input int ch, input logic [4:0] sub);
    return CHAN_BASE + 12'(ch * 32) + {7'h00, sub};
  endfunction

  // bounded wait for the next falling edge seen by the host
  task wait_frame;
    int c0;
    int n;
    c0 = readyCount;
    n = 0;
    while (readyCount == c0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (readyCount == c0) begin
      n_errors++;
      wrap_up;
    end
  endtask

  // pop whole frames until the queue is empty
  task drain;
    for (int k = 0; k < 4; k++) begin
      apb(LEVEL_OFS, 1'b0, 32'h0);
      if (rd[1:0] != 2'h0)
        for (int i = 0; i < 6; i++) apb(DATA_BASE + 12'(4 * i), 1'b0, 32'h0);
    end
  endtask

  task t_reset;
    apb(CLOCK_OFS, 1'b0, 32'h0);
    check(rd, CLOCK_RST);
    apb(chan(0, GCALH_SUB), 1'b0, 32'h0);
    check(rd, 32'h0000_8000);
    apb(12'h01c, 1'b0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(12'h002, 1'b1, 32'hffff_ffff);
    apb(CLOCK_OFS, 1'b0, 32'h0);
    check(rd, CLOCK_RST);
  endtask

  task t_rate;
    int t0;
    apb(CLOCK_OFS, 1'b1, 32'h0001_003f);
    wait_frame;
    drain;
    wait_frame;
    t0 = cyc;
    drain;
    check(32'(cyc - t0 < PERIOD), 32'h1);
    wait_frame;
    check(32'(cyc - t0), 32'(PERIOD));
  endtask

  task t_irq;
    apb(MASK_OFS, 1'b1, 32'h1);
    apb(STATUS_OFS, 1'b0, 32'h0);
    wait_frame;
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
    apb(STATUS_OFS, 1'b0, 32'h0);
    check({31'h0, rd[STAT_NEW_BIT]}, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    apb(MASK_OFS, 1'b1, 32'h0);
    wait_frame;
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask

  task t_ovf;
    int t0;
    repeat (3) wait_frame;
    t0 = cyc;
    wait_frame;
    check(32'(cyc - t0), 32'(2 * PERIOD));
    apb(LEVEL_OFS, 1'b0, 32'h0);
    check(rd, 32'h2);
    apb(STATUS_OFS, 1'b0, 32'h0);
    check({31'h0, rd[STAT_OVF_BIT]}, 32'h1);
    for (int i = 0; i < 5; i++) apb(DATA_BASE + 12'(4 * i), 1'b0, 32'h0);
    apb(LEVEL_OFS, 1'b0, 32'h0);
    check(rd, 32'h2);
    apb(DATA_BASE + 12'h014, 1'b0, 32'h0);
    apb(LEVEL_OFS, 1'b0, 32'h0);
    check(rd, 32'h1);
  endtask

  // ch0 offset and half gain, ch2/ch3 test inputs, ch5 switched off
  task t_cal;
    apb(chan(0, OCALH_SUB), 1'b1, 32'h1);
    apb(chan(0, GCALH_SUB), 1'b1, 32'h4000);
    apb(chan(2, CFG_SUB), 1'b1, 32'h2000);
    apb(chan(3, CFG_SUB), 1'b1, 32'h3000);
    apb(CLOCK_OFS, 1'b1, 32'h0001_001f);
    wait_frame;
    drain;
    wait_frame;
    for (int i = 0; i < 6; i++) begin
      apb(DATA_BASE + 12'(4 * i), 1'b0, 32'h0);
      check({8'h00, rd[23:0]}, {8'h00, CAL_EXP[i]});
    end
  endtask

  // gain code on ch1, late phase on ch4, then the dc filter on ch4
  task t_more;
    logic [23:0] r1;
    apb(GAIN_A_OFS, 1'b1, 32'h0000_0010);
    apb(chan(4, CFG_SUB), 1'b1, 32'h0000_007f);
    wait_frame;
    drain;
    wait_frame;
    drain;
    // mid-period input step: ch1 took its value, ch4 has not yet
    repeat (400) @(posedge clk);
    convIn[1] <= 24'h00_0300;
    convIn[4] <= 24'h00_0300;
    wait_frame;
    for (int i = 0; i < 6; i++) begin
      apb(DATA_BASE + 12'(4 * i), 1'b0, 32'h0);
      if (i == 1) check(rd, 32'h0000_0200);
      if (i == 4) check(rd, 32'h0000_0300);
    end
    apb(MODE_OFS, 1'b1, 32'h1);
    wait_frame;
    drain;
    wait_frame;
    apb(DATA_BASE + 12'h010, 1'b0, 32'h0);
    r1 = rd[23:0];
    drain;
    wait_frame;
    apb(DATA_BASE + 12'h010, 1'b0, 32'h0);
    check(32'(r1 < 24'h00_0300), 32'h1);
    check(32'(rd[23:0] < r1), 32'h1);
    drain;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    cyc = 0;
    n_errors = 0;
    n_checks = 0;
    req = '0;
    convIn = {24'h00_0200, 24'h00_0200, 24'h00_0200, 24'h00_0200,
              24'h00_0100, 24'h00_1000};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_rate;
    t_irq;
    t_ovf;
    t_cal;
    t_more;
    wrap_up;
  end
endmodule // tb
